// >>> src/utbg_pkg.sv
// Package: register map, field positions, counts and types of the serial port
package utbg_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_DATA   = 8'h04;
	localparam logic [7:0] ADR_TCTL   = 8'h08;
	localparam logic [7:0] ADR_RELOAD = 8'h0c;
	localparam logic [7:0] ADR_TLOW   = 8'h10;
	localparam logic [7:0] ADR_ISTAT  = 8'h14;
	localparam logic [7:0] ADR_IMASK  = 8'h18;

	// serial_control_reg field positions
	localparam int CTL_WLS  = 7;
	localparam int CTL_ONE  = 6;
	localparam int CTL_MCE  = 5;
	localparam int CTL_REN  = 4;
	localparam int CTL_TB9  = 3;
	localparam int CTL_RB9  = 2;
	localparam int CTL_TXF  = 1;
	localparam int CTL_RXF  = 0;

	// Interrupt status and mask positions
	localparam int IRQ_RX = 0;
	localparam int IRQ_TX = 1;

	// Timer control positions
	localparam int TCTL_RUN = 0;
	localparam int TCTL_SEL = 1;

	// Timer clock source codes
	localparam logic [2:0] SRC_SYS  = 3'h0;
	localparam logic [2:0] SRC_DIV4 = 3'h1;
	localparam logic [2:0] SRC_D12  = 3'h2;
	localparam logic [2:0] SRC_D48  = 3'h3;
	localparam logic [2:0] SRC_OSC8 = 3'h4;
	localparam logic [2:0] SRC_EXT  = 3'h5;

	// Prescaler end counts
	localparam logic [1:0] PRE4_END  = 2'h3;
	localparam logic [3:0] PRE12_END = 4'hb;
	localparam logic [1:0] PRE48_END = 2'h3;
	localparam logic [2:0] OSC8_END  = 3'h7;

	// Frame lengths in bits, start and stop included
	localparam logic [3:0] FRAME8 = 4'ha;
	localparam logic [3:0] FRAME9 = 4'hb;

	// Reset values
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [1:0] MASK_RST   = 2'h0;

	typedef enum logic {UTBG_RX_IDLE, UTBG_RX_BUSY} utbg_rx_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} utbg_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} utbg_wb_rsp_t;

endpackage

// >>> src/utbg_uart.sv
// Serial port with timer-driven bit clock, behind a classic Wishbone slave
`timescale 1ns/1ps

module utbg_uart (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire utbg_pkg::utbg_wb_req_t  wb_req_i,
	output utbg_pkg::utbg_wb_rsp_t       wb_rsp_o,
	input  wire logic                    rx_i,
	output logic                         tx_o,
	input  wire logic                    ext_osc_i,
	input  wire logic                    timer_external_input_i,
	output logic                         irq_o
);

	// Whole module state
	typedef struct packed {
		logic               ack;
		logic [31:0]        rdat;
		logic               irq;
		logic [2:0]         rx_sync;
		logic [2:0]         osc_sync;
		logic [2:0]         ext_sync;
		logic [3:0]         pre12;
		logic [1:0]         pre48;
		logic [2:0]         osc8;
		logic               word_length_select;
		logic               multidrop_enable;
		logic               rx_enable;
		logic               transmit_ninth_bit;
		logic               received_ninth_bit;
		logic               transmit_done_flag;
		logic               receive_done_flag;
		logic [1:0]         mask;
		logic               run;
		logic [2:0]         csel;
		logic [7:0]         timer_reload_byte;
		logic [7:0]         timer_low_counter;
		logic [7:0]         rx_counter;
		logic               tx_half;
		logic               rx_half;
		logic               tx_busy;
		logic [3:0]         tx_cnt;
		logic [10:0]        tx_shift;
		logic               tx_line;
		utbg_pkg::utbg_rx_t rx_state;
		logic [3:0]         rx_cnt;
		logic [9:0]         rx_shift;
		logic [7:0]         serial_data_buffer;
	} utbg_state_t;

	utbg_state_t state_ff;
	utbg_state_t nxt_state;

	logic        access;
	logic        wr;
	logic        tick;
	logic        osc_edge;
	logic        ext_edge;
	logic        tx_ovf;
	logic        rx_ovf;
	logic        tx_baud;
	logic        rx_sample;
	logic        rx_fall;
	logic        rx_bit;
	logic [3:0]  frame_len;
	logic [9:0]  rx_word;
	logic [7:0]  rx_data;
	logic        rx_ninth;
	logic        set_tx;
	logic        set_rx;
	logic [7:0]  ctrl_view;
	logic [31:0] rd_mux;

	// Next-state logic for bus, timer, transmitter and receiver
	always_comb begin
		nxt_state = state_ff;
		access    = wb_req_i.cyc & wb_req_i.stb & ~state_ff.ack;
		wr        = access & wb_req_i.we & wb_req_i.sel[0];
		set_tx    = 1'b0;
		set_rx    = 1'b0;
		rx_data   = 8'h00;
		rx_ninth  = 1'b0;
		rx_word   = 10'h000;

		// Two-stage synchronisers plus a third stage for edge detect
		nxt_state.rx_sync  = {state_ff.rx_sync[1:0], rx_i};
		nxt_state.osc_sync = {state_ff.osc_sync[1:0], ext_osc_i};
		nxt_state.ext_sync = {state_ff.ext_sync[1:0], timer_external_input_i};
		rx_bit   = state_ff.rx_sync[1];
		rx_fall  = ~state_ff.rx_sync[1] & state_ff.rx_sync[2];
		osc_edge = state_ff.osc_sync[1] & ~state_ff.osc_sync[2];
		ext_edge = state_ff.ext_sync[1] & ~state_ff.ext_sync[2];

		// Prescalers for the divided system clock and oscillator
		if (state_ff.pre12 == utbg_pkg::PRE12_END) begin
			nxt_state.pre12 = 4'h0;
			nxt_state.pre48 = state_ff.pre48 + 2'h1;
		end else begin
			nxt_state.pre12 = state_ff.pre12 + 4'h1;
		end
		if (osc_edge) begin
			nxt_state.osc8 = state_ff.osc8 + 3'h1;
		end

		// Timer clock source select
		unique case (state_ff.csel)
			utbg_pkg::SRC_SYS:  tick = 1'b1;
			utbg_pkg::SRC_DIV4: tick = state_ff.pre12[1:0] == utbg_pkg::PRE4_END;
			utbg_pkg::SRC_D12:  tick = state_ff.pre12 == utbg_pkg::PRE12_END;
			utbg_pkg::SRC_D48:  tick = (state_ff.pre12 == utbg_pkg::PRE12_END) &&
			                           (state_ff.pre48 == utbg_pkg::PRE48_END);
			utbg_pkg::SRC_OSC8: tick = osc_edge && (state_ff.osc8 == utbg_pkg::OSC8_END);
			utbg_pkg::SRC_EXT:  tick = ext_edge;
			default:            tick = 1'b0;
		endcase
		tick = tick & state_ff.run;

		// Transmit counter, 8-bit auto-reload
		tx_ovf = tick && (state_ff.timer_low_counter == 8'hff);
		if (tick) begin
			nxt_state.timer_low_counter = tx_ovf ? state_ff.timer_reload_byte
			                                     : state_ff.timer_low_counter + 8'h01;
		end

		// Hidden receive counter, same reload byte
		rx_ovf = tick && (state_ff.rx_counter == 8'hff);
		if (tick) begin
			nxt_state.rx_counter = rx_ovf ? state_ff.timer_reload_byte
			                              : state_ff.rx_counter + 8'h01;
		end

		// Overflows halved into bit-rate events
		tx_baud = tx_ovf & state_ff.tx_half;
		if (tx_ovf) begin
			nxt_state.tx_half = ~state_ff.tx_half;
		end
		rx_sample = rx_ovf & ~state_ff.rx_half;
		if (rx_ovf) begin
			nxt_state.rx_half = ~state_ff.rx_half;
		end

		frame_len = state_ff.word_length_select ? utbg_pkg::FRAME9
		                                        : utbg_pkg::FRAME8;

		// Transmitter: one bit per halved overflow
		if (state_ff.tx_busy && tx_baud) begin
			if (state_ff.tx_cnt == frame_len) begin
				nxt_state.tx_busy = 1'b0;
			end else begin
				nxt_state.tx_line  = state_ff.tx_shift[0];
				nxt_state.tx_shift = {1'b1, state_ff.tx_shift[10:1]};
				nxt_state.tx_cnt   = state_ff.tx_cnt + 4'h1;
				set_tx = state_ff.tx_cnt == (frame_len - 4'h1);
			end
		end

		// Receiver: start edge realigns the hidden counter
		unique case (state_ff.rx_state)
			utbg_pkg::UTBG_RX_IDLE: begin
				if (state_ff.rx_enable && rx_fall) begin
					nxt_state.rx_state   = utbg_pkg::UTBG_RX_BUSY;
					nxt_state.rx_counter = state_ff.timer_reload_byte;
					nxt_state.rx_half    = 1'b0;
					nxt_state.rx_cnt     = 4'h0;
				end
			end
			utbg_pkg::UTBG_RX_BUSY: begin
				if (rx_sample) begin
					rx_word = {rx_bit, state_ff.rx_shift[9:1]};
					nxt_state.rx_cnt = state_ff.rx_cnt + 4'h1;
					if (state_ff.rx_cnt == 4'h0) begin
						if (rx_bit) begin
							nxt_state.rx_state = utbg_pkg::UTBG_RX_IDLE; // False start
						end
					end else begin
						nxt_state.rx_shift = rx_word;
					end
					if (state_ff.rx_cnt == (frame_len - 4'h1)) begin
						nxt_state.rx_state = utbg_pkg::UTBG_RX_IDLE;
						if (state_ff.word_length_select) begin
							rx_data  = rx_word[7:0];
							rx_ninth = rx_word[8];
						end else begin
							rx_data  = rx_word[8:1];
							rx_ninth = rx_word[9];
						end
						set_rx = ~state_ff.receive_done_flag &&
						         (~state_ff.multidrop_enable || rx_ninth);
					end
				end
			end
		endcase

		// Register writes from the bus
		if (wr) begin
			unique case (wb_req_i.adr)
				utbg_pkg::ADR_CTRL: begin
					nxt_state.word_length_select = wb_req_i.dat[utbg_pkg::CTL_WLS];
					nxt_state.multidrop_enable   = wb_req_i.dat[utbg_pkg::CTL_MCE];
					nxt_state.rx_enable          = wb_req_i.dat[utbg_pkg::CTL_REN];
					nxt_state.transmit_ninth_bit = wb_req_i.dat[utbg_pkg::CTL_TB9];
					nxt_state.received_ninth_bit = wb_req_i.dat[utbg_pkg::CTL_RB9];
				end
				utbg_pkg::ADR_DATA: begin
					if (!state_ff.tx_busy) begin
						nxt_state.tx_busy  = 1'b1;
						nxt_state.tx_cnt   = 4'h0;
						nxt_state.tx_shift = state_ff.word_length_select ?
							{1'b1, state_ff.transmit_ninth_bit, wb_req_i.dat[7:0], 1'b0} :
							{2'b11, wb_req_i.dat[7:0], 1'b0};
					end
				end
				utbg_pkg::ADR_TCTL: begin
					nxt_state.run  = wb_req_i.dat[utbg_pkg::TCTL_RUN];
					nxt_state.csel = wb_req_i.dat[utbg_pkg::TCTL_SEL +: 3];
				end
				utbg_pkg::ADR_RELOAD: nxt_state.timer_reload_byte = wb_req_i.dat[7:0];
				utbg_pkg::ADR_TLOW:   nxt_state.timer_low_counter = wb_req_i.dat[7:0];
				utbg_pkg::ADR_ISTAT: begin
					// Only software clears the done flags
					if (wb_req_i.dat[utbg_pkg::IRQ_RX]) begin
						nxt_state.receive_done_flag = 1'b0;
					end
					if (wb_req_i.dat[utbg_pkg::IRQ_TX]) begin
						nxt_state.transmit_done_flag = 1'b0;
					end
				end
				utbg_pkg::ADR_IMASK:  nxt_state.mask = wb_req_i.dat[1:0];
				default: ;
			endcase
		end

		// Hardware set wins over a clear in the same cycle
		if (set_tx) begin
			nxt_state.transmit_done_flag = 1'b1;
		end
		if (set_rx) begin
			nxt_state.serial_data_buffer = rx_data;
			nxt_state.received_ninth_bit = rx_ninth;
			nxt_state.receive_done_flag  = 1'b1;
		end

		// Interrupt output from unmasked flags
		nxt_state.irq = (state_ff.receive_done_flag & state_ff.mask[utbg_pkg::IRQ_RX]) |
		                (state_ff.transmit_done_flag & state_ff.mask[utbg_pkg::IRQ_TX]);

		// Read data and acknowledge
		ctrl_view = {state_ff.word_length_select, 1'b1, state_ff.multidrop_enable,
		             state_ff.rx_enable, state_ff.transmit_ninth_bit,
		             state_ff.received_ninth_bit, state_ff.transmit_done_flag,
		             state_ff.receive_done_flag};
		unique case (wb_req_i.adr)
			utbg_pkg::ADR_CTRL:   rd_mux = {24'h000000, ctrl_view};
			utbg_pkg::ADR_DATA:   rd_mux = {24'h000000, state_ff.serial_data_buffer};
			utbg_pkg::ADR_TCTL:   rd_mux = {28'h0000000, state_ff.csel, state_ff.run};
			utbg_pkg::ADR_RELOAD: rd_mux = {24'h000000, state_ff.timer_reload_byte};
			utbg_pkg::ADR_TLOW:   rd_mux = {24'h000000, state_ff.timer_low_counter};
			utbg_pkg::ADR_ISTAT:  rd_mux = {30'h0, state_ff.transmit_done_flag,
			                                state_ff.receive_done_flag};
			utbg_pkg::ADR_IMASK:  rd_mux = {30'h0, state_ff.mask};
			default:              rd_mux = 32'h00000000;
		endcase
		nxt_state.ack = access;
		if (access && !wb_req_i.we) begin
			nxt_state.rdat = rd_mux;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff                   <= '0;
			state_ff.rx_sync           <= 3'h7;
			state_ff.tx_line           <= 1'b1;
			state_ff.tx_shift          <= 11'h7ff;
			state_ff.timer_reload_byte <= utbg_pkg::RELOAD_RST;
			state_ff.mask              <= utbg_pkg::MASK_RST;
			state_ff.rx_state          <= utbg_pkg::UTBG_RX_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outputs straight from state
	assign wb_rsp_o.ack = state_ff.ack;
	assign wb_rsp_o.dat = state_ff.rdat;
	assign tx_o         = state_ff.tx_line;
	assign irq_o        = state_ff.irq;

endmodule

// >>> verif/tb_utbg_uart.sv
// Testbench: register access, serial frames both ways, interrupts
`timescale 1ns/1ps
module tb_utbg_uart;
	logic                   clk_i, rst_i, rx_i, tx_o, ext_osc_i, irq_o;
	utbg_pkg::utbg_wb_req_t wb_req_i;
	utbg_pkg::utbg_wb_rsp_t wb_rsp_o;
	logic [31:0]            rd;
	logic [9:0]             fr;
	int                     err_count, comparisons;
	int                     tk[6] = '{1, 4, 12, 48, 32, 4};
	logic [7:0]             dv[6] = '{8'ha5, 8'h5a, 8'h01, 8'h80, 8'hc3, 8'h3c};
	utbg_uart DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
		.rx_i(rx_i), .tx_o(tx_o), .ext_osc_i(ext_osc_i), .timer_external_input_i(ext_osc_i),
		.irq_o(irq_o));
	utbg_node u_node (.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i));
	// System clock and a slower unrelated oscillator
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		ext_osc_i = 1'b0;
		#3;
		forever #20 ext_osc_i = ~ext_osc_i;
	end
	// One classic bus cycle; read data lands in rd
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
		wb_req_i <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
		@(posedge clk_i);
		// Wait for the answer; only the watchdog ends a hang
		while (wb_rsp_o.ack !== 1'b1) begin
			@(posedge clk_i);
		end
		rd = wb_rsp_o.dat;
		wb_req_i <= '0;
		@(posedge clk_i);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 8'h0);
		chk(rd, exp);
	endtask
	task automatic final_report();
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard
	initial begin
		#400000;
		err_count++;
		final_report();
	end
	initial begin
		wb_req_i = '0;
		err_count = 0;
		comparisons = 0;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(utbg_pkg::ADR_CTRL, 32'h40);
		rchk(utbg_pkg::ADR_RELOAD, 32'h0);
		rchk(8'h1c, 32'h0);
		wb(1'b1, utbg_pkg::ADR_RELOAD, 8'hfc);
		wb(1'b1, utbg_pkg::ADR_CTRL, 8'h10);
		// Transmit from every timer clock source, interrupt masked
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, utbg_pkg::ADR_TCTL, {4'h0, 3'(i), 1'b1});
			fork
				u_node.recv(9, 8 * tk[i], fr);
				wb(1'b1, utbg_pkg::ADR_DATA, dv[i]);
			join
			chk({22'h0, fr}, {24'h1, dv[i]});
			rchk(utbg_pkg::ADR_ISTAT, 32'h2);
			chk({31'h0, irq_o}, 32'h0);
			rchk(utbg_pkg::ADR_DATA, 32'h0);
			wb(1'b1, utbg_pkg::ADR_ISTAT, 8'h2);
			repeat (8 * tk[i]) @(posedge clk_i);
		end
		wb(1'b1, utbg_pkg::ADR_TCTL, 8'h01);
		wb(1'b1, utbg_pkg::ADR_IMASK, 8'h3);
		// Receive, then overrun leaves the held byte
		u_node.send(10'h13c, 9, 8);
		rchk(utbg_pkg::ADR_ISTAT, 32'h1);
		chk({31'h0, irq_o}, 32'h1);
		rchk(utbg_pkg::ADR_CTRL, 32'h55);
		u_node.send(10'h177, 9, 8);
		rchk(utbg_pkg::ADR_DATA, 32'h3c);
		chk({31'h0, irq_o}, 32'h1);
		wb(1'b1, utbg_pkg::ADR_ISTAT, 8'h1);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		// Second byte arrives while the first is read
		u_node.send(10'h112, 9, 8);
		fork
			u_node.send(10'h134, 9, 8);
			begin
				repeat (30) @(posedge clk_i);
				rchk(utbg_pkg::ADR_DATA, 32'h12);
				wb(1'b1, utbg_pkg::ADR_ISTAT, 8'h1);
			end
		join
		rchk(utbg_pkg::ADR_DATA, 32'h34);
		wb(1'b1, utbg_pkg::ADR_ISTAT, 8'h1);
		// Eight-bit frame with a low stop bit is dropped under multidrop
		wb(1'b1, utbg_pkg::ADR_CTRL, 8'h30);
		u_node.send(10'h0aa, 9, 8);
		rchk(utbg_pkg::ADR_ISTAT, 32'h0);
		rchk(utbg_pkg::ADR_DATA, 32'h34);
		// Nine-bit frames with multidrop filtering
		wb(1'b1, utbg_pkg::ADR_CTRL, 8'hb0);
		u_node.send(10'h299, 10, 8);
		rchk(utbg_pkg::ADR_ISTAT, 32'h0);
		u_node.send(10'h381, 10, 8);
		rchk(utbg_pkg::ADR_DATA, 32'h81);
		rchk(utbg_pkg::ADR_CTRL, 32'hf5);
		wb(1'b1, utbg_pkg::ADR_ISTAT, 8'h1);
		wb(1'b1, utbg_pkg::ADR_CTRL, 8'hb8);
		fork
			u_node.recv(10, 8, fr);
			wb(1'b1, utbg_pkg::ADR_DATA, 8'h6e);
		join
		chk({22'h0, fr}, 32'h36e);
		rchk(utbg_pkg::ADR_ISTAT, 32'h2);
		chk({31'h0, irq_o}, 32'h1);
		// Stopped timer keeps a value written to the low counter
		wb(1'b1, utbg_pkg::ADR_TCTL, 8'h00);
		wb(1'b1, utbg_pkg::ADR_TLOW, 8'h5a);
		repeat (8) @(posedge clk_i);
		rchk(utbg_pkg::ADR_TLOW, 32'h5a);
		rchk(utbg_pkg::ADR_TCTL, 32'h0);
		final_report();
	end
endmodule

// >>> verif/utbg_chk.sv
// Checker: bus handshake, serial bit timing and interrupt relations
`timescale 1ns/1ps
module utbg_chk (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire utbg_pkg::utbg_wb_req_t wb_req_i,
	input  wire utbg_pkg::utbg_wb_rsp_t wb_rsp_o,
	input  wire logic                   tx_o,
	input  wire logic                   irq_o
);
	logic       take;
	logic       wr;
	logic [1:0] mask_ff;
	logic [3:0] clr_ff;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Request taken by the slave
	assign take = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
	assign wr = take & wb_req_i.we & wb_req_i.sel[0];
	// Shadow mask and recent writes that may lower the interrupt
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_ff <= 2'h0;
			clr_ff <= 4'h0;
		end else begin
			clr_ff <= {clr_ff[2:0], wr & (wb_req_i.adr == utbg_pkg::ADR_ISTAT
				|| wb_req_i.adr == utbg_pkg::ADR_IMASK)};
			if (wr && wb_req_i.adr == utbg_pkg::ADR_IMASK)
				mask_ff <= wb_req_i.dat[1:0];
		end
	end
	sequence s_take;
		take;
	endsequence
	sequence s_rd_ctrl;
		take && !wb_req_i.we && wb_req_i.adr == utbg_pkg::ADR_CTRL;
	endsequence
	property p_ack_resp;
		s_take |=> wb_rsp_o.ack;
	endproperty
	property p_ack_pulse;
		wb_rsp_o.ack |=> !wb_rsp_o.ack;
	endproperty
	property p_ack_cause;
		wb_rsp_o.ack |-> $past(take);
	endproperty
	property p_ctrl_one;
		s_rd_ctrl |=> wb_rsp_o.ack && wb_rsp_o.dat[7:0] == (wb_rsp_o.dat[7:0] | 8'h40);
	endproperty
	property p_dat_upper;
		wb_rsp_o.dat[31:8] == 24'h0;
	endproperty
	property p_dat_hold;
		!(take && !wb_req_i.we) |=> $stable(wb_rsp_o.dat);
	endproperty
	property p_irq_mask;
		irq_o |-> (mask_ff != 2'h0 || $past(mask_ff) != 2'h0);
	endproperty
	property p_irq_sticky;
		$fell(irq_o) |-> clr_ff != 4'h0;
	endproperty
	property p_tx_bit;
		$changed(tx_o) |=> $stable(tx_o);
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_ctrl_one: assert property (p_ctrl_one) else $error("control bit 6 not one");
	a_dat_upper: assert property (p_dat_upper) else $error("read data upper bits set");
	a_dat_hold: assert property (p_dat_hold) else $error("read data changed");
	a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
	a_irq_sticky: assert property (p_irq_sticky) else $error("flag cleared alone");
	a_tx_bit: assert property (p_tx_bit) else $error("serial bit too short");
endmodule
bind utbg_uart utbg_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
	.wb_rsp_o(wb_rsp_o), .tx_o(tx_o), .irq_o(irq_o));

// >>> verif/utbg_node.sv
// Far serial node: drives the receive pin and captures transmitted frames
`timescale 1ns/1ps
module utbg_node (
	input  wire logic clk_i,
	input  wire logic tx_i,
	output logic      rx_o
);
	// Line idles high between frames
	initial rx_o = 1'b1;
	// Start, n bits LSB first (stop is the last), then idle
	task automatic send(input logic [9:0] v, input int n, input int bt);
		rx_o <= 1'b0;
		repeat (bt) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			rx_o <= v[i];
			repeat (bt) @(posedge clk_i);
		end
		rx_o <= 1'b1;
		repeat (bt) @(posedge clk_i);
	endtask
	// Sample mid-bit after the start edge
	task automatic recv(input int n, input int bt, output logic [9:0] v);
		v = 10'h0;
		@(negedge tx_i);
		repeat (bt / 2) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			repeat (bt) @(posedge clk_i);
			v[i] = tx_i;
		end
	endtask
endmodule
